/* pll_div_pkg.sv */
package pll_div_pkg;
    // Fixed reference divide: 1 MHz down to 1 kHz, toggled every half period
    localparam int unsigned REF_RATIO  = 1000;
    localparam logic [9:0]  REF_HALF   = 10'h1f4;
    localparam logic [9:0]  REF_CNT_RST = 10'h000;
    // Local oscillator divide by ten, toggled every five input edges
    localparam int unsigned LO_RATIO   = 10;
    localparam logic [2:0]  LO_HALF    = 3'h5;
    localparam logic [2:0]  LO_CNT_RST = 3'h0;
    // Feedback chain shape: three 4-bit down counters and one final flop
    localparam int unsigned STAGE_W    = 4;
    localparam int unsigned NSTAGE     = 3;
    localparam int unsigned FB_W       = 13;
    localparam int unsigned FB_RATIO   = 5550;
    // Chain divides by preset plus two (reload edge and hold edge)
    localparam logic [12:0] FB_PRESET  = 13'h15ac;
    localparam logic [3:0]  STAGE_RST  = 4'h0;
endpackage : pll_div_pkg

/* stage_if.sv */
`timescale 1ns/1ps
interface stage_if #(parameter int unsigned W = pll_div_pkg::STAGE_W);
    logic         step;
    logic         load;
    logic [W-1:0] preset;
    logic [W-1:0] value;
    logic         carry;
    modport stage (input step, input load, input preset, output value, output carry);
    modport ctrl  (output step, output load, output preset, input value, input carry);
endinterface : stage_if

/* div_stage.sv */
`timescale 1ns/1ps
module div_stage #(
    parameter int unsigned W = pll_div_pkg::STAGE_W
) (
    input  wire logic clk,
    input  wire logic rst_n,
    stage_if.stage    port_if
);
    typedef struct packed {
        logic [W-1:0] value;
    } stage_state_t;

    stage_state_t st_ff;
    stage_state_t nxt_st;

    // Load from preset pins, else count down on each step
    always_comb
    begin
        nxt_st = st_ff;
        if (port_if.load)
        begin
            nxt_st.value = port_if.preset;
        end
        else if (port_if.step)
        begin
            nxt_st.value = W'(st_ff.value - 1'b1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Carry marks the stage at zero
    assign port_if.value = st_ff.value;
    assign port_if.carry = (st_ff.value == '0);

    property p_stage_dec;
        @(posedge clk) disable iff (!rst_n)
        (port_if.step && !port_if.load) |=> (st_ff.value == W'($past(st_ff.value) - 1'b1));
    endproperty
    a_stage_dec: assert property (p_stage_dec)
        else $error("stage did not count down on step");

    property p_stage_load;
        @(posedge clk) disable iff (!rst_n)
        port_if.load |=> (st_ff.value == $past(port_if.preset));
    endproperty
    a_stage_load: assert property (p_stage_load)
        else $error("stage did not take its preset");
endmodule : div_stage

/* pll_divider_chain.sv */
`timescale 1ns/1ps
module pll_divider_chain #(
    parameter int unsigned STAGE_W = pll_div_pkg::STAGE_W,
    parameter int unsigned NSTAGE  = pll_div_pkg::NSTAGE
) (
    input  wire logic                            clk,
    input  wire logic                            rst_n,
    input  wire logic                            ref_in,
    input  wire logic                            vco_in,
    input  wire logic [NSTAGE*STAGE_W:0]         fb_preset,
    output logic                                 ref_div_out,
    output logic                                 fb_div_out,
    output logic                                 lo_out
);
    typedef struct packed {
        logic       ref_prev;
        logic       vco_prev;
        logic [9:0] ref_cnt;
        logic       ref_out;
        logic [2:0] lo_cnt;
        logic       lo_out;
        logic       msb;
        logic       reload;
    } top_state_t;

    top_state_t                st_ff;
    top_state_t                nxt_st;
    logic                      ref_rise;
    logic                      vco_rise;
    logic                      decode;
    logic                      step_base;
    logic [NSTAGE-1:0]         step_vec;
    logic [NSTAGE-1:0]         carry_vec;
    logic [NSTAGE*STAGE_W-1:0] count_vec;

    // Rising edges of the two square waves
    assign ref_rise = ref_in && !st_ff.ref_prev;
    assign vco_rise = vco_in && !st_ff.vco_prev;

    assign decode = (&carry_vec) && !st_ff.msb;

    // no step while decoding or reloading
    assign step_base = vco_rise && !st_ff.reload && !decode;

    // Down counter stages chained by borrow
    genvar g;
    generate
        for (g = 0; g < NSTAGE; g++)
        begin : gen_stage
            stage_if #(.W(STAGE_W)) sif ();
            if (g == 0)
            begin : gen_first
                // first stage steps at VCO rate
                assign step_vec[g] = step_base;
            end
            else
            begin : gen_next
                assign step_vec[g] = step_vec[g-1] && carry_vec[g-1];
            end
            assign sif.step   = step_vec[g];
            assign sif.load   = vco_rise && st_ff.reload;
            assign sif.preset = fb_preset[g*STAGE_W +: STAGE_W];
            assign carry_vec[g] = sif.carry;
            // Stage counts gathered for the chain checks
            assign count_vec[g*STAGE_W +: STAGE_W] = sif.value;
            div_stage #(.W(STAGE_W)) u_stage (
                .clk     (clk),
                .rst_n   (rst_n),
                .port_if (sif)
            );
        end
    endgenerate

    // Next state of dividers and reload flop
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.ref_prev = ref_in;
        nxt_st.vco_prev = vco_in;
        if (ref_rise)
        begin
            if (st_ff.ref_cnt == pll_div_pkg::REF_HALF - 10'h001)
            begin
                nxt_st.ref_cnt = pll_div_pkg::REF_CNT_RST;
                nxt_st.ref_out = !st_ff.ref_out;
            end
            else
            begin
                nxt_st.ref_cnt = st_ff.ref_cnt + 10'h001;
            end
        end
        if (vco_rise)
        begin
            if (st_ff.lo_cnt == pll_div_pkg::LO_HALF - 3'h1)
            begin
                nxt_st.lo_cnt = pll_div_pkg::LO_CNT_RST;
                nxt_st.lo_out = !st_ff.lo_out;
            end
            else
            begin
                nxt_st.lo_cnt = st_ff.lo_cnt + 3'h1;
            end
        end
        if (step_vec[NSTAGE-1] && carry_vec[NSTAGE-1])
        begin
            nxt_st.msb = !st_ff.msb;
        end
        // reload sequence sets the period to fb_preset plus two
        if (vco_rise)
        begin
            if (st_ff.reload)
            begin
                nxt_st.reload = 1'b0;
                nxt_st.msb    = fb_preset[NSTAGE*STAGE_W];
            end
            else if (decode)
            begin
                nxt_st.reload = 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign ref_div_out = st_ff.ref_out;
    assign fb_div_out  = st_ff.msb;
    assign lo_out      = st_ff.lo_out;

    sequence s_terminal;
        vco_rise && decode && !st_ff.reload;
    endsequence

    sequence s_reload_edge;
        st_ff.reload && vco_rise;
    endsequence

    property p_ref_toggle;
        @(posedge clk) disable iff (!rst_n)
        $changed(st_ff.ref_out) |->
            ($past(ref_rise) && $past(st_ff.ref_cnt) == 10'h1f3);
    endproperty
    a_ref_toggle: assert property (p_ref_toggle)
        else $error("reference output toggled at wrong count");

    property p_lo_toggle;
        @(posedge clk) disable iff (!rst_n)
        $changed(st_ff.lo_out) |-> ($past(vco_rise) && $past(st_ff.lo_cnt) == 3'h4);
    endproperty
    a_lo_toggle: assert property (p_lo_toggle)
        else $error("local oscillator toggled at wrong count");

    property p_decode_arms;
        @(posedge clk) disable iff (!rst_n)
        s_terminal |=> st_ff.reload && $stable(st_ff.msb);
    endproperty
    a_decode_arms: assert property (p_decode_arms)
        else $error("terminal count did not arm reload");

    property p_reload_holds;
        @(posedge clk) disable iff (!rst_n)
        (st_ff.reload && !vco_rise) |=> st_ff.reload;
    endproperty
    a_reload_holds: assert property (p_reload_holds)
        else $error("reload pulse ended before an input edge");

    property p_reload_load;
        @(posedge clk) disable iff (!rst_n)
        s_reload_edge |=> !st_ff.reload && st_ff.msb == $past(fb_preset[NSTAGE*STAGE_W]);
    endproperty
    a_reload_load: assert property (p_reload_load)
        else $error("reload did not load final flop preset");

    // Count held at terminal and while reload waits
    property p_no_step_in_reload;
        @(posedge clk) disable iff (!rst_n)
        ((st_ff.reload || decode) && !(st_ff.reload && vco_rise)) |=>
            $stable({st_ff.msb, count_vec});
    endproperty
    a_no_step_in_reload: assert property (p_no_step_in_reload)
        else $error("chain count moved during reload");

    // Whole chain drops by exactly one per step
    property p_carry_chain;
        @(posedge clk) disable iff (!rst_n)
        step_vec[0] |=> ({st_ff.msb, count_vec} == $past({st_ff.msb, count_vec}) - 13'h0001);
    endproperty
    a_carry_chain: assert property (p_carry_chain)
        else $error("chain did not count down by one");

    property p_msb_cause;
        @(posedge clk) disable iff (!rst_n)
        ($changed(st_ff.msb) && !$past(st_ff.reload)) |->
            $past(step_vec[NSTAGE-1] && carry_vec[NSTAGE-1]);
    endproperty
    a_msb_cause: assert property (p_msb_cause)
        else $error("final flop changed without third carry");

    property p_fb_output;
        @(posedge clk) disable iff (!rst_n)
        $changed(fb_div_out) |-> $past(vco_rise);
    endproperty
    a_fb_output: assert property (p_fb_output)
        else $error("feedback output moved without VCO edge");
endmodule : pll_divider_chain

/* vco_ref_model.sv */
`timescale 1ns/1ps
module vco_ref_model (
    input  wire logic clk,
    input  wire logic run,
    input  wire logic slow,
    output logic      vco_in,
    output logic      ref_in,
    output int        vco_rises,
    output int        ref_rises
);
    logic [1:0] ref_ph;

    // Idle levels before the first edge
    initial
    begin
        vco_in = 1'b0;
        ref_in = 1'b0;
        ref_ph = 2'h0;
        vco_rises = 0;
        ref_rises = 0;
    end

    // Square waves move on the falling edge, held low while stopped
    always @(negedge clk)
    begin
        if (!run)
        begin
            vco_in <= 1'b0;
            ref_in <= 1'b0;
        end
        else
        begin
            // Slow oscillator stretches the current phase by one clock
            if (!slow)
                vco_in <= !vco_in;
            if (!slow && !vco_in)
                vco_rises <= vco_rises + 1;
            // Fast reference, two clocks high and two low
            ref_ph <= ref_ph + 2'h1;
            ref_in <= (ref_ph == 2'h1) ? 1'b1 : (ref_ph == 2'h3) ? 1'b0 : ref_in;
            if (ref_ph == 2'h1)
                ref_rises <= ref_rises + 1;
        end
    end
endmodule : vco_ref_model

/* pll_divider_chain_tb.sv */
`timescale 1ns/1ps
module pll_divider_chain_tb;
    logic        clk;
    logic        rst_n;
    logic        slow;
    logic [12:0] fb_preset;
    logic        vco_in;
    logic        ref_in;
    logic        ref_div_out;
    logic        fb_div_out;
    logic        lo_out;
    logic [2:0]  outs;
    logic [2:0]  last;
    logic [2:0]  armed;
    logic [31:0] rng;
    int          vco_rises;
    int          ref_rises;
    int          mark [3];
    int          fb_seen;
    int          cycles;
    int          num_errors;
    int          cmp_count;
    string       names [3] = '{"ref_div_out", "fb_div_out", "lo_out"};

    pll_divider_chain u_dut (.clk(clk), .rst_n(rst_n), .ref_in(ref_in), .vco_in(vco_in),
        .fb_preset(fb_preset), .ref_div_out(ref_div_out), .fb_div_out(fb_div_out),
        .lo_out(lo_out));
    vco_ref_model u_far (.clk(clk), .run(rst_n), .slow(slow), .vco_in(vco_in),
        .ref_in(ref_in), .vco_rises(vco_rises), .ref_rises(ref_rises));

    assign outs = {lo_out, fb_div_out, ref_div_out};

    always #5 clk = ~clk;

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    // Input rises behind each output
    function automatic int rises(input int idx);
        return (idx == 0) ? ref_rises : vco_rises;
    endfunction : rises

    // Expected input rises per output phase of the given level
    function automatic int exp_len(input int idx, input logic lvl);
        int span;
        span = 1 << (pll_div_pkg::NSTAGE * pll_div_pkg::STAGE_W);
        if (idx == 0)
            return pll_div_pkg::REF_RATIO / 2;
        if (idx == 2)
            return pll_div_pkg::LO_RATIO / 2;
        // Final flop high down to span, low for the rest plus reload
        return lvl ? int'(fb_preset) - (span - 1) : span + 1;
    endfunction : exp_len

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : check

    task automatic summarize;
        if (num_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    task automatic wait_fb(input int n);
        int goal;
        goal = fb_seen + n;
        while (fb_seen < goal)
            @(negedge clk);
    endtask : wait_fb

    task automatic set_preset(input logic [12:0] p);
        @(negedge clk);
        fb_preset <= p;
        armed[1] <= 1'b0;
    endtask : set_preset

    // Random stalls of the oscillator
    always @(negedge clk)
    begin
        rng = xorshift(rng);
        slow <= (rng[2:0] == 3'h0);
    end

    // Phase length of every output toggle, first one after reset (and for fb_div_out after a preset change) skipped
    always @(negedge clk)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (!rst_n)
                armed[i] = 1'b0;
            else if (outs[i] !== last[i])
            begin
                if (armed[i])
                    check(names[i], rises(i) - mark[i], exp_len(i, last[i]));
                armed[i] = 1'b1;
                mark[i] = rises(i);
                fb_seen += (i == 1) ? 1 : 0;
            end
        end
        last = outs;
    end

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 95000)
        begin
            num_errors++;
            summarize();
        end
    end

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        slow = 1'b0;
        fb_preset = pll_div_pkg::FB_PRESET;
        rng = 32'h000069b7;
        last = 3'h0;
        armed = 3'h0;
        fb_seen = 0;
        cycles = 0;
        num_errors = 0;
        cmp_count = 0;
        repeat (3) @(negedge clk);
        rst_n <= 1'b1;
        wait_fb(3);
        set_preset(13'h1000);
        wait_fb(3);
        @(posedge clk);
        set_preset(13'h1000 | {5'h00, rng[7:0]});
        wait_fb(3);
        @(negedge clk);
        rst_n <= 1'b0;
        repeat (2) @(negedge clk);
        check("outputs_in_reset", {29'h0, outs}, 32'h0);
        rst_n <= 1'b1;
        wait_fb(3);
        summarize();
    end
endmodule : pll_divider_chain_tb
